// file: design/tbp_port.sv
`timescale 1ns/1ps
module tbp_port
   import tbp_pkg::*;
#(
   parameter int LINK_LOSS_CYC = (LINK_LOSS_US * 1000) / CLK_NS,
   parameter int POL_TMO_CYC   = (POL_TMO_US * 1000) / CLK_NS,
   parameter int JAB_CYC       = (JAB_US * 1000 + CLK_NS - 1) / CLK_NS,
   parameter int UNJAB_CYC     = (UNJAB_US * 1000 + CLK_NS - 1) / CLK_NS
)(
   input  wire logic          clock,
   input  wire logic          sys_rst,
   input  wire tbp_rx_s       rx_pins,
   input  wire logic          an_done,
   input  wire logic          an_start,
   input  wire logic          page_rx,
   input  wire logic          page_base,
   input  wire logic [AW-1:0] reg_addr,
   input  wire logic [DW-1:0] reg_wdata,
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   output logic      [DW-1:0] reg_rdata,
   output tbp_mii_s           mii,
   output logic               line_tx_en,
   output logic               link_pulse_en,
   output logic               scram_bypass,
   output logic               fiber_en,
   output logic               loop_en,
   output logic               an_restart
);

   localparam int LW = $clog2(LINK_LOSS_CYC + 1);
   localparam int PW = $clog2(POL_TMO_CYC + 1);
   localparam int JW = $clog2(JAB_CYC + 1);
   localparam int UW = $clog2(UNJAB_CYC + 1);

   // refuse timers the counters cannot serve
   if (LINK_LOSS_CYC < 2 || POL_TMO_CYC < 2 || JAB_CYC < 2 || UNJAB_CYC < 2)
   begin : g_chk
      $error("tbp_port: timer parameters must be at least 2");
   end

   // byte address of a register index
   function automatic logic [AW-1:0] baddr(input int idx);
      baddr = AW'(idx * 4);
   endfunction : baddr

   // final nibble with missing bit positions padded with ones
   function automatic logic [3:0] pad_tail(input logic [3:0] t, input logic [2:0] n);
      logic [3:0] m;
      m = 4'hF;
      for (int i = 0; i < 4; i++)
      begin
         if (i < int'(n))
            m[i] = 1'b0;
      end
      pad_tail = t | m;
   endfunction : pad_tail

   // two-stage synchroniser and nibble clock edge
   tbp_rx_s s1_q;
   tbp_rx_s s2_q;
   logic    nclk_q;

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         s1_q   <= '0;
         s2_q   <= '0;
         nclk_q <= 1'b0;
      end
      else
      begin
         s1_q   <= rx_pins;
         s2_q   <= s1_q;
         nclk_q <= s2_q.nclk;
      end
   end

   logic       pol_q, pol_d;
   logic       edge_e;
   logic       txa;
   logic [3:0] nibx;
   logic [3:0] tailx;

   assign nibx   = s2_q.nib ^ {4{pol_q}};
   assign tailx  = s2_q.tail ^ {4{pol_q}};
   assign edge_e = s2_q.nclk & ~nclk_q;
   assign txa    = s2_q.tx_en;

   // register state
   logic [15:0] cfg_q, cfg_d;
   logic [15:0] xctl_q, xctl_d;
   logic        prx_q, prx_d;
   logic        base_q, base_d;
   logic        andone_q, andone_d;
   logic [DW-1:0] rdata_q, rdata_d;

   // receive path state
   logic       crs_q, crs_d;
   logic       dv_q, dv_d;
   logic [3:0] rxd_q, rxd_d;
   logic [3:0] prev_q, prev_d;
   logic       prev_v_q, prev_v_d;
   logic       frm_q, frm_d;
   logic       tail_q, tail_d;
   logic [3:0] tailn_q, tailn_d;
   logic       endw_q, endw_d;

   // receive path: preamble, carrier sense, dribble handling
   always_comb
   begin
      crs_d    = crs_q;
      dv_d     = dv_q;
      rxd_d    = rxd_q;
      prev_d   = prev_q;
      prev_v_d = prev_v_q;
      frm_d    = frm_q;
      tail_d   = tail_q;
      tailn_d  = tailn_q;
      endw_d   = endw_q;
      if (edge_e)
      begin
         dv_d  = 1'b0;
         rxd_d = 4'h0;
         if (tail_q)
         begin
            dv_d   = 1'b1;
            rxd_d  = tailn_q;
            tail_d = 1'b0;
         end
         else if (s2_q.eof && (frm_q || prev_v_q))
         begin
            // last full nibble, then optional tail
            dv_d     = 1'b1;
            rxd_d    = prev_q;
            frm_d    = 1'b0;
            prev_v_d = 1'b0;
            // one partial nibble kept, second withheld
            tail_d   = (s2_q.drib != 3'h0);
            tailn_d  = pad_tail(tailx, s2_q.drib);
            if (!cfg_q[CFG_CRSAL])
               crs_d = 1'b0;
            endw_d = cfg_q[CFG_CRSAL];
         end
         else if (s2_q.nib_vld)
         begin
            if (!cfg_q[CFG_PRE])
            begin
               // preamble stripped, rx_dv low until delimiter
               // held 5 nibble leads, delimiter D follows
               dv_d  = frm_q | s2_q.sfd;
               rxd_d = (frm_q | s2_q.sfd) ? prev_q : 4'h0;
               crs_d = crs_q | s2_q.sfd;
            end
            else
            begin
               dv_d  = prev_v_q;
               rxd_d = prev_v_q ? prev_q : 4'h0;
               crs_d = 1'b1;
            end
            frm_d    = frm_q | s2_q.sfd;
            prev_d   = nibx;
            prev_v_d = 1'b1;
         end
         else
         begin
            // carrier gone without end marker
            frm_d    = 1'b0;
            prev_v_d = 1'b0;
            if (!endw_q)
               crs_d = 1'b0;
         end
         if (endw_q && !dv_d)
         begin
            crs_d  = 1'b0;
            endw_d = 1'b0;
         end
      end
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         crs_q    <= 1'b0;
         dv_q     <= 1'b0;
         rxd_q    <= 4'h0;
         prev_q   <= 4'h0;
         prev_v_q <= 1'b0;
         frm_q    <= 1'b0;
         tail_q   <= 1'b0;
         tailn_q  <= 4'h0;
         endw_q   <= 1'b0;
      end
      else
      begin
         crs_q    <= crs_d;
         dv_q     <= dv_d;
         rxd_q    <= rxd_d;
         prev_q   <= prev_d;
         prev_v_q <= prev_v_d;
         frm_q    <= frm_d;
         tail_q   <= tail_d;
         tailn_q  <= tailn_d;
         endw_q   <= endw_d;
      end
   end

   // link, polarity and jabber state
   logic          lnk_q, lnk_d;
   logic [LW-1:0] ltmr_q, ltmr_d;
   logic [PW-1:0] ptmr_q, ptmr_d;
   logic [3:0]    lpc_q, lpc_d;
   logic [2:0]    eofc_q, eofc_d;
   logic          jab_q, jab_d;
   logic [JW-1:0] jtmr_q, jtmr_d;
   logic [UW-1:0] utmr_q, utmr_d;
   logic          anr_q, anr_d;
   logic          txg_q, txg_d;
   logic          lpen_q, lpen_d;
   logic          loop_q, loop_d;
   logic          act;
   logic          force_lnk;

   assign act       = edge_e & (s2_q.lp | s2_q.nib_vld);
   assign force_lnk = cfg_q[CFG_FORCE];

   // link test, polarity detection, jabber
   always_comb
   begin
      lnk_d  = lnk_q;
      ltmr_d = ltmr_q;
      pol_d  = pol_q;
      ptmr_d = ptmr_q;
      lpc_d  = lpc_q;
      eofc_d = eofc_q;
      jab_d  = jab_q;
      jtmr_d = jtmr_q;
      utmr_d = utmr_q;
      anr_d  = 1'b0;
      // pulses or data keep the link alive
      if (act)
      begin
         lnk_d  = 1'b1;
         ltmr_d = '0;
      end
      else if (lnk_q)
      begin
         ltmr_d = ltmr_q + 1'b1;
         if (ltmr_q == LW'(LINK_LOSS_CYC - 1))
         begin
            lnk_d  = 1'b0;
            ltmr_d = '0;
            anr_d  = xctl_q[XCTL_AN] & ~force_lnk;
         end
      end
      // consecutive inverted pulses and end markers
      if (edge_e && s2_q.lp)
      begin
         lpc_d = s2_q.lp_inv ? lpc_q + 1'b1 : 4'h0;
         if (s2_q.lp_inv && lpc_q == 4'(POL_LP_N - 1))
         begin
            pol_d = ~pol_q;
            lpc_d = 4'h0;
         end
      end
      if (edge_e && s2_q.eof)
      begin
         eofc_d = s2_q.eof_inv ? eofc_q + 1'b1 : 3'h0;
         if (s2_q.eof_inv && eofc_q == 3'(POL_EOF_N - 1))
         begin
            pol_d  = ~pol_q;
            eofc_d = 3'h0;
         end
      end
      if (act)
         ptmr_d = '0;
      else if (ptmr_q == PW'(POL_TMO_CYC - 1))
      begin
         pol_d  = 1'b0;
         lpc_d  = 4'h0;
         eofc_d = 3'h0;
         ptmr_d = '0;
      end
      else
         ptmr_d = ptmr_q + 1'b1;
      if (txa && !jab_q)
      begin
         jtmr_d = jtmr_q + 1'b1;
         if (jtmr_q == JW'(JAB_CYC - 1))
         begin
            jab_d  = 1'b1;
            jtmr_d = '0;
         end
      end
      else
         jtmr_d = '0;
      if (jab_q && !txa && !cfg_q[CFG_UNJD])
      begin
         utmr_d = utmr_q + 1'b1;
         if (utmr_q == UW'(UNJAB_CYC - 1))
         begin
            jab_d  = 1'b0;
            utmr_d = '0;
         end
      end
      else
         utmr_d = '0;
      // transmit gated by link unless forced
      txg_d  = txa & (lnk_q | force_lnk) & ~jab_q;
      // link pulses whenever mac is idle
      lpen_d = ~txa;
      loop_d = xctl_q[XCTL_LOOP] & ~jab_q;
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         lnk_q  <= 1'b0;
         ltmr_q <= '0;
         pol_q  <= 1'b0;
         ptmr_q <= '0;
         lpc_q  <= 4'h0;
         eofc_q <= 3'h0;
         jab_q  <= 1'b0;
         jtmr_q <= '0;
         utmr_q <= '0;
         anr_q  <= 1'b0;
         txg_q  <= 1'b0;
         lpen_q <= 1'b1;
         loop_q <= 1'b0;
      end
      else
      begin
         lnk_q  <= lnk_d;
         ltmr_q <= ltmr_d;
         pol_q  <= pol_d;
         ptmr_q <= ptmr_d;
         lpc_q  <= lpc_d;
         eofc_q <= eofc_d;
         jab_q  <= jab_d;
         jtmr_q <= jtmr_d;
         utmr_q <= utmr_d;
         anr_q  <= anr_d;
         txg_q  <= txg_d;
         lpen_q <= lpen_d;
         loop_q <= loop_d;
      end
   end

   logic lnk_st;

   assign lnk_st = lnk_q | force_lnk;

   // register file, read-to-clear page flags
   always_comb
   begin
      cfg_d    = cfg_q;
      xctl_d   = xctl_q;
      prx_d    = prx_q;
      base_d   = base_q;
      andone_d = andone_q;
      rdata_d  = '0;
      if (reg_wr && reg_addr == baddr(IDX_CFG))
         cfg_d = reg_wdata[15:0];
      if (reg_wr && reg_addr == baddr(IDX_XCTL))
         xctl_d = reg_wdata[15:0];
      if (reg_rd)
      begin
         unique case (reg_addr)
            baddr(IDX_STAT):  rdata_d[STAT_LINK] = lnk_st;
            baddr(IDX_ANEXP):
            begin
               rdata_d[ANX_PRX]  = prx_q;
               rdata_d[ANX_BASE] = base_q;
               prx_d  = 1'b0;
               base_d = 1'b0;
            end
            baddr(IDX_CFG):   rdata_d[15:0] = cfg_q;
            baddr(IDX_PSTAT):
            begin
               rdata_d[PST_LINK]   = lnk_st;
               rdata_d[PST_ANDONE] = andone_q;
               rdata_d[PST_POL]    = pol_q;
               rdata_d[PST_JAB]    = jab_q;
            end
            baddr(IDX_XCTL):  rdata_d[15:0] = xctl_q;
            default:          rdata_d = '0;
         endcase
      end
      // alternate mode clears on new negotiation
      if (an_start && cfg_q[CFG_ALTNP])
      begin
         prx_d  = 1'b0;
         base_d = 1'b0;
      end
      if (an_start)
         andone_d = 1'b0;
      if (an_done)
         andone_d = 1'b1;
      if (page_rx)
      begin
         prx_d  = 1'b1;
         base_d = page_base;
      end
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cfg_q    <= CFG_RST;
         xctl_q   <= XCTL_RST;
         prx_q    <= 1'b0;
         base_q   <= 1'b0;
         andone_q <= 1'b0;
         rdata_q  <= '0;
      end
      else
      begin
         cfg_q    <= cfg_d;
         xctl_q   <= xctl_d;
         prx_q    <= prx_d;
         base_q   <= base_d;
         andone_q <= andone_d;
         rdata_q  <= rdata_d;
      end
   end

   // fixed mode flops: scrambler bypassed, fiber off
   logic scb_q;
   logic fib_q;

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         scb_q <= 1'b1;
         fib_q <= 1'b0;
      end
      else
      begin
         scb_q <= 1'b1;
         fib_q <= 1'b0;
      end
   end

   // outputs straight from flops
   assign reg_rdata     = rdata_q;
   assign mii           = '{crs: crs_q, rx_dv: dv_q, rxd: rxd_q};
   assign line_tx_en    = txg_q;
   assign link_pulse_en = lpen_q;
   assign scram_bypass  = scb_q;
   assign fiber_en      = fib_q;
   assign loop_en       = loop_q;
   assign an_restart    = anr_q;

endmodule : tbp_port

// file: include/tbp_pkg.sv
package tbp_pkg;

   // clock
   localparam int CLK_NS = 50;

   // register index and byte address
   localparam int AW        = 10;
   localparam int DW        = 32;
   localparam int IDX_STAT  = 1;
   localparam int IDX_ANEXP = 6;
   localparam int IDX_CFG   = 16;
   localparam int IDX_PSTAT = 17;
   localparam int IDX_XCTL  = 30;

   // field positions
   localparam int STAT_LINK  = 2;
   localparam int ANX_PRX    = 1;
   localparam int ANX_BASE   = 5;
   localparam int CFG_ALTNP  = 1;
   localparam int CFG_PRE    = 5;
   localparam int CFG_CRSAL  = 7;
   localparam int CFG_UNJD   = 10;
   localparam int CFG_FORCE  = 14;
   localparam int PST_POL    = 5;
   localparam int PST_ANDONE = 7;
   localparam int PST_JAB    = 9;
   localparam int PST_LINK   = 10;
   localparam int XCTL_AN    = 0;
   localparam int XCTL_LOOP  = 1;

   // reset values
   localparam logic [15:0] CFG_RST  = 16'h0000;
   localparam logic [15:0] XCTL_RST = 16'h0001;

   // delimiter nibbles, polarity thresholds
   localparam logic [3:0] SFD_LO    = 4'h5;
   localparam logic [3:0] SFD_HI    = 4'hD;
   localparam int         POL_LP_N  = 8;
   localparam int         POL_EOF_N = 4;

   // timing in microseconds
   localparam int LINK_LOSS_US = 100000;
   localparam int POL_TMO_US   = 100000;
   localparam int JAB_US       = 20000;
   localparam int UNJAB_US     = 500;

   // decoded line and mac pins, all from outside the clock domain
   typedef struct packed {
      logic       nclk;
      logic       nib_vld;
      logic [3:0] nib;
      logic       sfd;
      logic       eof;
      logic       eof_inv;
      logic [2:0] drib;
      logic [3:0] tail;
      logic       lp;
      logic       lp_inv;
      logic       tx_en;
   } tbp_rx_s;

   // mii receive group
   typedef struct packed {
      logic       crs;
      logic       rx_dv;
      logic [3:0] rxd;
   } tbp_mii_s;

endpackage : tbp_pkg

// file: testbench/tbp_line_model.sv
`timescale 1ns/1ps
// line decoder and mac stand-in: drives nibble slots, logs the mii
module tbp_line_model
   import tbp_pkg::*;
(
   input  wire logic     clock,
   input  wire logic     tx_en,
   input  wire tbp_mii_s mii,
   output tbp_rx_s       pins
);
   tbp_rx_s  f_q = '0;
   tbp_mii_s got_q[$];

   // mac enable rides in the last field
   assign pins = {f_q[18:1], tx_en};

   // eight clocks a slot; fields change while nclk is low
   task automatic slot(input tbp_rx_s f);
      if (!f.nib_vld)
         f.nib = ~f_q.nib; // released lines never repeat the last nibble
      f.nclk = 1'b0;
      @(posedge clock);
      f_q <= f;
      repeat (4) @(posedge clock);
      got_q.push_back(mii); // result of the slot before
      f_q.nclk <= 1'b1;
      repeat (3) @(posedge clock);
   endtask : slot
endmodule : tbp_line_model

// file: testbench/tbp_port_asserts.sv
`timescale 1ns/1ps
// timing relations seen at the port pins
module tbp_port_asserts
   import tbp_pkg::*;
#(
   parameter int JAB_CYC = 30
)(
   input wire logic          clock,
   input wire logic          sys_rst,
   input wire tbp_rx_s       rx_pins,
   input wire logic          page_rx,
   input wire logic [AW-1:0] reg_addr,
   input wire logic          reg_rd,
   input wire logic [DW-1:0] reg_rdata,
   input wire tbp_mii_s      mii,
   input wire logic          line_tx_en,
   input wire logic          link_pulse_en,
   input wire logic          scram_bypass,
   input wire logic          fiber_en,
   input wire logic          loop_en,
   input wire logic          an_restart
);
   int unsigned hi_q;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);

   // cycles of unbroken transmit enable
   always_ff @(posedge clock or posedge sys_rst)
      if (sys_rst)
         hi_q <= 0;
      else
         hi_q <= rx_pins.tx_en ? hi_q + 1 : 0;

   // page flag read with no new page arriving
   sequence s_rd_page;
      reg_rd && reg_addr == AW'(IDX_ANEXP * 4) && !page_rx;
   endsequence

   a_scram_bypass: assert property (scram_bypass)
      else $error("scrambler in path");
   a_no_fiber: assert property (!fiber_en)
      else $error("fiber path on");
   a_pulse_idle: assert property ((!rx_pins.tx_en) [*5] |-> link_pulse_en)
      else $error("no link pulses while idle");
   a_pulse_busy: assert property (rx_pins.tx_en [*5] |-> !link_pulse_en)
      else $error("link pulses during transmit");
   a_tx_gated: assert property ((!rx_pins.tx_en) [*5] |-> !line_tx_en)
      else $error("transmit without mac enable");
   a_jab_cut: assert property (hi_q > JAB_CYC + 6 |-> !line_tx_en && !loop_en)
      else $error("jabber did not cut off");
   a_dv_crs: assert property ($rose(mii.rx_dv) |-> mii.crs)
      else $error("rx_dv rose without crs");
   a_crs_fall: assert property ($fell(mii.rx_dv) |-> !mii.crs)
      else $error("crs outlived rx_dv");
   a_restart_once: assert property (an_restart |=> !an_restart)
      else $error("restart pulse too long");
   a_page_clear: assert property (s_rd_page ##1 !page_rx ##1 s_rd_page |=> reg_rdata[6:0] == 7'h00)
      else $error("page flags not cleared by read");
endmodule : tbp_port_asserts

bind tbp_port tbp_port_asserts #(.JAB_CYC(JAB_CYC)) i_tbp_port_asserts (
   .clock(clock), .sys_rst(sys_rst), .rx_pins(rx_pins), .page_rx(page_rx),
   .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mii(mii),
   .line_tx_en(line_tx_en), .link_pulse_en(link_pulse_en), .scram_bypass(scram_bypass),
   .fiber_en(fiber_en), .loop_en(loop_en), .an_restart(an_restart));

// file: testbench/tbp_port_tb.sv
`timescale 1ns/1ps
// frame, link, jabber, polarity and page flag tests
module tbp_port_tb
   import tbp_pkg::*;
;
   localparam int LL = 40;
   localparam int PT = 60;
   localparam int JC = 30;
   localparam int UC = 20;
   logic          clock = 1'b0;
   logic          sys_rst = 1'b1;
   logic          tx_en = 1'b0;
   logic          an_done = 1'b0, an_start = 1'b0, page_rx = 1'b0, page_base = 1'b0;
   logic          reg_wr = 1'b0, reg_rd = 1'b0;
   logic [AW-1:0] reg_addr = '0;
   logic [DW-1:0] reg_wdata = '0;
   logic [DW-1:0] reg_rdata;
   tbp_rx_s       rx_pins;
   tbp_mii_s      mii;
   logic          line_tx_en, link_pulse_en, scram_bypass, fiber_en, loop_en, an_restart;
   int            fail_count = 0, checks = 0, restarts = 0, n;

   always #(CLK_NS / 2) clock = ~clock;

   tbp_port #(.LINK_LOSS_CYC(LL), .POL_TMO_CYC(PT), .JAB_CYC(JC), .UNJAB_CYC(UC)) i_tbp_port (
      .clock(clock), .sys_rst(sys_rst), .rx_pins(rx_pins), .an_done(an_done), .an_start(an_start),
      .page_rx(page_rx), .page_base(page_base), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mii(mii), .line_tx_en(line_tx_en),
      .link_pulse_en(link_pulse_en), .scram_bypass(scram_bypass), .fiber_en(fiber_en),
      .loop_en(loop_en), .an_restart(an_restart));
   tbp_line_model i_tbp_line_model (.clock(clock), .tx_en(tx_en), .mii(mii), .pins(rx_pins));

   // counts negotiation restarts
   always @(negedge clock)
      if (an_restart === 1'b1)
         restarts++;

   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", s, e, g);
      end
   endtask : chk

   task automatic cyc(input int c);
      repeat (c) @(posedge clock);
      @(negedge clock);
   endtask : cyc

   task automatic wr(input int i, input logic [DW-1:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= AW'(i * 4);
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : wr

   // masked read, data taken in the cycle after the strobe
   task automatic rd(input int i, input logic [31:0] m, input logic [31:0] e, input string s);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= AW'(i * 4);
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      chk(s, e, reg_rdata & m);
   endtask : rd

   // one-cycle pulse on {an_done, an_start, page_rx, page_base}
   task automatic pulse(input logic [3:0] w);
      @(posedge clock);
      {an_done, an_start, page_rx, page_base} <= w;
      @(posedge clock);
      {an_done, an_start, page_rx, page_base} <= '0;
   endtask : pulse

   task automatic sl(input tbp_rx_s f);
      i_tbp_line_model.slot(f);
   endtask : sl

   // preamble, delimiter, two body nibbles, end marker with dribble bits
   // kp keeps the preamble, iv drives every nibble and tail bit inverted
   task automatic frame(input logic [2:0] dr, input logic [3:0] tl, input logic al, input logic kp,
                        input logic iv);
      tbp_mii_s   e;
      tbp_mii_s   g;
      logic [3:0] pad;
      logic [3:0] x;
      x = {4{iv}};
      pad = (dr > 4) ? tl : tl | 4'(4'hF << dr);
      wr(IDX_CFG, (32'(al) << CFG_CRSAL) | (32'(kp) << CFG_PRE));
      i_tbp_line_model.got_q.delete();
      repeat (3) sl('{nib_vld:1'b1, nib:SFD_LO ^ x, default:'0});
      sl('{nib_vld:1'b1, nib:SFD_HI ^ x, sfd:1'b1, default:'0});
      sl('{nib_vld:1'b1, nib:4'hA ^ x, default:'0});
      sl('{nib_vld:1'b1, nib:4'h3 ^ x, default:'0});
      sl('{eof:1'b1, drib:dr, tail:tl ^ x, default:'0});
      repeat (3) sl('0);
      for (int k = 1; k < 10; k++)
      begin
         case (k)
            1: e = '{kp, 1'b0, 4'h0};
            2, 3: e = '{kp, kp, SFD_LO};
            4: e = '{1'b1, 1'b1, SFD_LO};
            5: e = '{1'b1, 1'b1, SFD_HI};
            6: e = '{1'b1, 1'b1, 4'hA};
            7: e = '{al, 1'b1, 4'h3};
            8: e = '{al && dr != 0, dr != 0, pad};
            default: e = '0;
         endcase
         g = i_tbp_line_model.got_q[k];
         if (!e.rx_dv)
         begin
            e.rxd = '0;
            g.rxd = '0;
         end
         chk("mii slot", 32'(e), 32'(g));
      end
   endtask : frame

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : give_verdict

   // main sequence
   initial
   begin
      repeat (4) @(posedge clock);
      sys_rst <= 1'b0;
      rd(IDX_CFG, '1, 32'(CFG_RST), "cfg reset");
      rd(IDX_XCTL, '1, 32'(XCTL_RST), "xctl reset");
      wr(IDX_STAT, '1);
      rd(IDX_STAT, '1, 0, "status read only");
      wr(5, '1);
      rd(5, '1, 0, "unmapped");
      chk("scram_bypass", 1, scram_bypass);
      chk("fiber_en", 0, fiber_en);
      chk("link_pulse_en", 1, link_pulse_en);
      $display("test reset finished");
      frame(3'd0, 4'h0, 1'b0, 1'b0, 1'b0);
      frame(3'd1, 4'h0, 1'b1, 1'b0, 1'b0);
      frame(3'd4, 4'h9, 1'b0, 1'b0, 1'b0);
      frame(3'd5, 4'h6, 1'b1, 1'b0, 1'b0);
      frame(3'd7, 4'hB, 1'b0, 1'b0, 1'b0);
      frame(3'd0, 4'h0, 1'b1, 1'b1, 1'b0);
      $display("test frames finished");
      n = restarts;
      cyc(LL + 10);
      sl('{lp:1'b1, default:'0});
      rd(IDX_STAT, '1, 32'h4, "link");
      rd(IDX_PSTAT, 32'h400, 32'h400, "link 2");
      @(posedge clock) tx_en <= 1'b1;
      cyc(5);
      chk("tx on link", 1, line_tx_en);
      chk("pulses in tx", 0, link_pulse_en);
      @(posedge clock) tx_en <= 1'b0;
      cyc(LL + 10);
      chk("restarts", n + 2, restarts);
      rd(IDX_STAT, '1, 0, "link lost");
      @(posedge clock) tx_en <= 1'b1;
      cyc(5);
      chk("tx no link", 0, line_tx_en);
      wr(IDX_CFG, 32'h1 << CFG_FORCE);
      cyc(3);
      chk("forced tx", 1, line_tx_en);
      wr(IDX_XCTL, 32'h3);
      cyc(1);
      chk("loop on", 1, loop_en);
      cyc(JC);
      chk("jab tx", 0, line_tx_en);
      chk("jab loop", 0, loop_en);
      rd(IDX_PSTAT, 32'h200, 32'h200, "jabber");
      @(posedge clock) tx_en <= 1'b0;
      cyc(UC + 10);
      chk("unjab", 1, loop_en);
      wr(IDX_CFG, (32'h1 << CFG_FORCE) | (32'h1 << CFG_UNJD));
      @(posedge clock) tx_en <= 1'b1;
      cyc(JC + 10);
      @(posedge clock) tx_en <= 1'b0;
      cyc(UC + 10);
      chk("unjab held", 0, loop_en);
      wr(IDX_CFG, 32'h1 << CFG_FORCE);
      cyc(UC + 10);
      chk("unjab late", 1, loop_en);
      wr(IDX_CFG, 0);
      $display("test link and jabber finished");
      sl('{lp:1'b1, default:'0});
      repeat (POL_EOF_N - 1) sl('{eof:1'b1, eof_inv:1'b1, default:'0});
      rd(IDX_PSTAT, 32'h20, 0, "pol eof 3");
      sl('{eof:1'b1, eof_inv:1'b1, default:'0});
      rd(IDX_PSTAT, 32'h20, 32'h20, "pol eof 4");
      cyc(PT + 10);
      rd(IDX_PSTAT, 32'h20, 0, "pol timeout");
      repeat (POL_LP_N - 1) sl('{lp:1'b1, lp_inv:1'b1, default:'0});
      rd(IDX_PSTAT, 32'h20, 0, "pol lp 7");
      sl('{lp:1'b1, lp_inv:1'b1, default:'0});
      rd(IDX_PSTAT, 32'h20, 32'h20, "pol lp 8");
      frame(3'd2, 4'h5, 1'b0, 1'b0, 1'b1);
      $display("test polarity finished");
      pulse(4'b0011);
      rd(IDX_ANEXP, '1, 32'h22, "page flags");
      rd(IDX_ANEXP, '1, 0, "page cleared");
      pulse(4'b0010);
      pulse(4'b0100);
      rd(IDX_ANEXP, '1, 32'h2, "page held");
      wr(IDX_CFG, 32'h1 << CFG_ALTNP);
      pulse(4'b0010);
      pulse(4'b0100);
      rd(IDX_ANEXP, '1, 0, "page auto clear");
      pulse(4'b1000);
      rd(IDX_PSTAT, 32'h80, 32'h80, "neg complete");
      $display("test pages finished");
      give_verdict();
   end

   // cuts a hang short; the tests need about 1200 cycles
   initial
   begin
      repeat (20000) @(posedge clock);
      fail_count++;
      give_verdict();
   end
endmodule : tbp_port_tb
